// ==== rtl/conv_settings.sv ====
/*
 * Settings register and conversion sequencer for a serial converter.
 * Assumes sclk/cs_n/din come from the master in another clock domain;
 * the analog conversion itself is outside and reports through conv_done.
 */
module conv_settings
  import cfg_pkg::*;
(
  input  wire logic        mclk,             // System clock
  input  wire logic        srst,             // Synchronous reset
  input  wire logic        sclk,             // Link clock
  input  wire logic        cs_n,             // Chip select, low active
  input  wire logic        din,              // Serial data in
  input  wire logic        conv_done,        // Analog engine finished
  input  wire logic [15:0] conv_data,        // Finished result
  output logic             result_out_ready_n, // Data or ready out
  output logic             dout_oe,          // Drive enable for pin
  output logic             pullup_en_q,      // Weak pullup request
  output logic             conv_start_q,     // Pulse: begin conversion
  output conv_cfg_t        conv_cfg_q,       // Settings for conversion
  output logic [15:0]      settings_q        // Full register readback
);

  logic [15:0] cfg_q;        // Stored writable fields
  logic [15:0] result_q;     // Buffered conversion result
  logic [15:0] word_lk;      // Word captured on link side
  logic        vld_lk;       // Link-side word flag, cleared on deselect
  logic        vld_s1_q;     // Word flag sync stage one
  logic        vld_s2_q;     // Word flag sync stage two
  logic        vld_s3_q;     // Previous synced word flag
  logic        dout_s1_q;    // Link data bit sync stage one
  logic        dout_s2_q;    // Link data bit sync stage two
  logic        wr_ok;        // Qualified word arrives this cycle
  logic [15:0] cfg_nxt;      // Register value after this cycle
  logic        cs_s1_q;      // Chip select sync stage one
  logic        cs_s2_q;      // Chip select sync stage two
  logic        dout_lk;      // Link-side data bit
  logic        ready_q;      // New result not yet fetched
  logic        cs_prev_q;    // Previous synced select
  conv_state_t state_q;      // Conversion sequencer
  logic [15:0] readback;     // Value the master sees

  // Rising edge of the synced flag gives one event per captured word
  wire word_evt = vld_s2_q & ~vld_s3_q; // New word arrived

  // Start bit masked, reserved bit forced
  always_comb begin
    readback              = cfg_q;
    readback[START_BIT]   = 1'b0;
    readback[RSVD_BIT]    = 1'b1;
  end

  // Next register value; a start by this same write must see it
  always_comb begin
    wr_ok   = word_evt && (word_lk[QUAL_LSB +: 2] == QUAL_VALID);
    cfg_nxt = wr_ok ? word_lk : cfg_q;
  end

  // Link engine; the readback and result are quasi-static while a frame
  // runs, which is the usual compromise for a slave with no link reset
  // synchroniser. A write mid-frame already shows in the readback half of the same frame.
  link_shift u_link (
    .sclk        (sclk),
    .cs_n        (cs_n),
    .din         (din),
    .result_word (result_q),
    .cfg_word    (readback),
    .dout        (dout_lk),
    .word_q      (word_lk),
    .word_vld_q  (vld_lk)
  );

  // Two-flop synchronisers for the word flag, chip select and data bit;
  // the data bit lags a link edge by up to three system clocks
  always_ff @(posedge mclk) begin
    if (srst) begin
      vld_s1_q  <= 1'b0;
      vld_s2_q  <= 1'b0;
      vld_s3_q  <= 1'b0;
      cs_s1_q   <= 1'b1;
      cs_s2_q   <= 1'b1;
      cs_prev_q <= 1'b1;
      dout_s1_q <= 1'b0;
      dout_s2_q <= 1'b0;
    end else begin
      vld_s1_q  <= vld_lk;
      vld_s2_q  <= vld_s1_q;
      vld_s3_q  <= vld_s2_q;
      cs_s1_q   <= cs_n;
      cs_s2_q   <= cs_s1_q;
      cs_prev_q <= cs_s2_q;
      dout_s1_q <= dout_lk;
      dout_s2_q <= dout_s1_q;
    end
  end

  // Register update; word held stable since the flag rose two clocks ago
  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg_q <= CFG_RESET;
    end else begin
      cfg_q <= cfg_nxt;
    end
  end

  // Sequencer: single-shot start or continuous restart
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q      <= ST_IDLE;
      conv_start_q <= 1'b0;
      conv_cfg_q   <= '0;
    end else begin
      conv_start_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          // Start bit only honoured while powered down
          if (cfg_q[MODE_BIT] == MODE_CONT ||
              (wr_ok && word_lk[START_BIT] && word_lk[MODE_BIT] == MODE_SINGLE)) begin
            state_q      <= ST_CONV;
            conv_start_q <= 1'b1;
            // Snapshot so later writes leave this conversion alone
            conv_cfg_q.mux  <= cfg_nxt[MUX_LSB +: 3];
            conv_cfg_q.gain <= cfg_nxt[GAIN_LSB +: 3];
            conv_cfg_q.rate <= cfg_nxt[RATE_LSB +: 3];
            conv_cfg_q.temp <= cfg_nxt[TEMP_BIT];
          end
        end
        ST_CONV: begin
          // Start writes here are ignored by design
          if (conv_done) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          // Continuous mode loops regardless of chip select
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Result buffer and ready flag; new result wins over a fetch
  always_ff @(posedge mclk) begin
    if (srst) begin
      result_q <= 16'h0000;
      ready_q  <= 1'b0;
    end else if (state_q == ST_CONV && conv_done) begin
      result_q <= conv_data;
      ready_q  <= 1'b1;
    end else if (!cs_s2_q && cs_prev_q) begin
      ready_q  <= 1'b0;
    end
  end

  // Pin drive: ready indication, or data while selected
  always_ff @(posedge mclk) begin
    if (srst) begin
      result_out_ready_n <= 1'b1;
      dout_oe            <= 1'b0;
      pullup_en_q        <= 1'b1;
      settings_q         <= CFG_RESET;
    end else begin
      settings_q  <= readback;
      pullup_en_q <= cs_s2_q & cfg_q[PULL_BIT];
      dout_oe     <= ~cs_s2_q;
      result_out_ready_n <= cs_prev_q ? ~ready_q : dout_s2_q;
    end
  end

endmodule : conv_settings

// ==== rtl/cfg_pkg.sv ====
/*
 * Shared constants and types for the converter settings register block.
 * Assumes a 50 MHz system clock; the serial link runs on its own clock.
 */
package cfg_pkg;

  // Register width and reset value
  localparam int          CFG_W         = 16;
  localparam logic [15:0] CFG_RESET     = 16'h058B;

  // Field positions
  localparam int          START_BIT     = 15;
  localparam int          MUX_LSB       = 12;
  localparam int          GAIN_LSB      = 9;
  localparam int          MODE_BIT      = 8;
  localparam int          RATE_LSB      = 5;
  localparam int          TEMP_BIT      = 4;
  localparam int          PULL_BIT      = 3;
  localparam int          QUAL_LSB      = 1;
  localparam int          RSVD_BIT      = 0;

  // Qualifier code that lets a write land
  localparam logic [1:0]  QUAL_VALID    = 2'h1;
  // Mode bit values
  localparam logic        MODE_CONT     = 1'b0;
  localparam logic        MODE_SINGLE   = 1'b1;

  // Frame lengths in link clocks
  localparam logic [5:0]  FRAME_HALF    = 6'h10;

  // Base conversion time at the slowest rate, in microseconds, and the
  // derived system clock count; faster rates shift this down.
  localparam int          CLK_MHZ       = 50;
  localparam int          CONV_US_8SPS  = 125000;
  localparam int          CONV_CYC_8SPS = CONV_US_8SPS * CLK_MHZ;

  // Settings that feed the conversion engine
  typedef struct packed {
    logic [2:0] mux;
    logic [2:0] gain;
    logic [2:0] rate;
    logic       temp;
  } conv_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_DONE = 2'b10
  } conv_state_t;

endpackage : cfg_pkg

// ==== rtl/link_shift.sv ====
/*
 * Link-side serial engine. Runs on the link clock, is reset by chip select
 * high. Assumes the master uses mode 1: launch on rise, sample on fall.
 */
module link_shift
  import cfg_pkg::*;
(
  input  wire logic        sclk,        // Link clock from master
  input  wire logic        cs_n,        // Chip select, low active
  input  wire logic        din,         // Serial data in
  input  wire logic [15:0] result_word, // Stable result snapshot
  input  wire logic [15:0] cfg_word,    // Stable settings readback
  output logic             dout,        // Serial data out bit
  output logic [15:0]      word_q,      // Captured first word
  output logic             word_vld_q   // Word captured, held till deselect
);

  logic [5:0]  bit_cnt_q;  // Falling edges seen in this frame
  logic [15:0] shin_q;     // Incoming shift register
  logic [31:0] shout_q;    // Outgoing shift register
  logic        first_q;    // No rise yet this frame

  // Capture on falling edges; cs_n high clears the frame state. The word
  // flag is a level, not a toggle, so deselect gives it a known value.
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_q  <= 6'h00;
      shin_q     <= 16'h0000;
      word_vld_q <= 1'b0;
    end else begin
      shin_q <= {shin_q[14:0], din};
      // Sixteenth fall completes the settings word
      if (bit_cnt_q == FRAME_HALF - 6'h01) begin
        word_vld_q <= 1'b1;
      end
      if (bit_cnt_q != 6'h3F) begin
        bit_cnt_q <= bit_cnt_q + 6'h01;
      end
    end
  end

  // Word complete after sixteenth falling edge; kept until the next frame
  always_ff @(negedge sclk) begin
    if (!cs_n && bit_cnt_q == FRAME_HALF - 6'h01) begin
      word_q <= {shin_q[14:0], din};
    end
  end

  // Shift out on rising edges, MSB first; result then readback
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      first_q <= 1'b1;
      shout_q <= 32'h0000_0000;
    end else if (first_q) begin
      first_q <= 1'b0;
      shout_q <= {result_word[14:0], 17'h00000};
    end else if (bit_cnt_q == FRAME_HALF) begin
      // Second half echoes settings just written this frame
      shout_q <= {cfg_word[14:0], 17'h00000};
    end else begin
      shout_q <= {shout_q[30:0], 1'b0};
    end
  end

  // First bit of each half comes straight from its snapshot, later ones from shift
  logic msb_q;
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      msb_q <= 1'b0;
    end else if (first_q) begin
      msb_q <= result_word[15];
    end else if (bit_cnt_q == FRAME_HALF) begin
      msb_q <= cfg_word[15];
    end else begin
      msb_q <= shout_q[31];
    end
  end

  assign dout = msb_q;

endmodule : link_shift

// ==== bench/conv_settings_chk.sv ====
/* Checker for the settings register block, bound to conv_settings.
   Assumes one mclk domain with srst synchronous and active high. */
module conv_settings_chk
  import cfg_pkg::*;
(
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic        sclk,
  input wire logic        cs_n,
  input wire logic        din,
  input wire logic        conv_done,
  input wire logic [15:0] conv_data,
  input wire logic        result_out_ready_n,
  input wire logic        dout_oe,
  input wire logic        pullup_en_q,
  input wire logic        conv_start_q,
  input wire conv_cfg_t   conv_cfg_q,
  input wire logic [15:0] settings_q
);
  timeunit 1ns;
  timeprecision 100ps;
  // All checks live in the system clock domain
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  a_reset_value: assert property (disable iff (1'b0) srst |=> settings_q == 16'h058B)
    else $error("settings not at reset value");
  a_start_zero: assert property (!settings_q[15])
    else $error("start bit reads one");
  a_rsvd_one: assert property (settings_q[0])
    else $error("reserved bit reads zero");
  // Only qualified writes land, so the stored code stays valid
  a_qual_kept: assert property (settings_q[2:1] == 2'h1)
    else $error("unqualified write landed");
  a_start_pulse: assert property (conv_start_q |=> !conv_start_q)
    else $error("start longer than one cycle");
  // Snapshot may load with the start pulse or one cycle after it
  a_snap_start: assert property ($changed(conv_cfg_q) |-> conv_start_q || $past(conv_start_q))
    else $error("settings changed under a running conversion");
  a_pull_bit: assert property (pullup_en_q |-> settings_q[3] || $past(settings_q[3]))
    else $error("pullup without enable bit");
  a_pull_sel: assert property (dout_oe && $past(dout_oe) |-> !pullup_en_q)
    else $error("pullup while selected");
  a_ready_new: assert property (conv_done && !dout_oe |-> ##[1:3] (!result_out_ready_n || dout_oe))
    else $error("ready not low after new result");
  a_cont_run: assert property (!settings_q[8] && conv_done |-> ##[1:4] conv_start_q)
    else $error("continuous mode did not restart");
  c_start: cover property (conv_start_q);
  c_ready: cover property (conv_done && !dout_oe);
  c_write: cover property ($changed(settings_q));
endmodule : conv_settings_chk

bind conv_settings conv_settings_chk i_conv_settings_chk (
  .mclk(mclk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .din(din), .conv_done(conv_done),
  .conv_data(conv_data), .result_out_ready_n(result_out_ready_n), .dout_oe(dout_oe),
  .pullup_en_q(pullup_en_q), .conv_start_q(conv_start_q), .conv_cfg_q(conv_cfg_q),
  .settings_q(settings_q));

// ==== bench/serial_master_model.sv ====
/* Serial master model: frames of 16 or 32 link clocks in mode 1.
   Assumes the device output lags a link edge by up to three mclk. */
module serial_master_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout
);
  timeunit 1ns;
  timeprecision 100ps;
  // Link idle: clock low, deselected
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
  end
  // Bits are spaced out because the output is resampled on mclk
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx   = '0;
    cs_n = 1'b0;
    #80;
    for (int i = 0; i < n; i++) begin
      if (i == 16) #140; // Let the write land before readback
      sclk = 1'b1;
      din  = tx[31-i]; // MSB first, launched on rise
      #6 sclk = 1'b0; // Device captures on this fall
      #66 rx = {rx[30:0], dout};
    end
    #20 cs_n = 1'b1;
    din = ~din; // Released line must not look held
    #100;
  endtask : xfer
endmodule : serial_master_model

// ==== bench/conv_settings_test.sv ====
/* Self-checking bench for conv_settings with a serial master model.
   Assumes 50 MHz mclk; the link clock exists only within frames. */
module conv_settings_test
  import cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, srst, sclk, cs_n, din, conv_done, rdy_n, oe, pull, start;
  logic [15:0] conv_data, settings;
  logic [31:0] rx;
  conv_cfg_t   cfg;
  int num_errors = 0, tests_run = 0, starts = 0;
  conv_settings i_conv_settings (.mclk(mclk), .srst(srst), .sclk(sclk), .cs_n(cs_n),
    .din(din), .conv_done(conv_done), .conv_data(conv_data), .result_out_ready_n(rdy_n),
    .dout_oe(oe), .pullup_en_q(pull), .conv_start_q(start), .conv_cfg_q(cfg),
    .settings_q(settings));
  serial_master_model i_serial_master_model (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(rdy_n));
  // 20 ns system clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Count start pulses seen
  always @(posedge mclk) if (start === 1'b1) starts <= starts + 1;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  // One result from the analog side
  task automatic done_pulse(input logic [15:0] d);
    @(posedge mclk);
    conv_done <= 1'b1;
    conv_data <= d;
    @(posedge mclk);
    conv_done <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : done_pulse
  task automatic t_refused();
    for (int q = 0; q < 4; q++) begin
      if (q != 1) begin
        i_serial_master_model.xfer({16'hBBF0 | {13'h0, 2'(q), 1'b0}, 16'h0}, 16, rx);
        check("refused", settings, 16'h058B);
      end
    end
    check("no start", starts, 0);
  endtask : t_refused
  task automatic t_write();
    i_serial_master_model.xfer({16'hBBF2, 16'h0}, 32, rx);
    check("readback", rx[15:0], 16'h3BF3);
    check("settings", settings, 16'h3BF3);
    check("pullup", pull, 1'b0);
    check("start", starts, 1);
    check("snapshot", cfg, {3'h3, 3'h5, 3'h7, 1'b1});
    i_serial_master_model.xfer({16'hBBF2, 16'h0}, 16, rx);
    check("busy start", starts, 1);
  endtask : t_write
  task automatic t_result();
    done_pulse(16'hA55A);
    check("ready", rdy_n, 1'b0);
    i_serial_master_model.xfer(32'h0, 16, rx);
    check("result", rx[15:0], 16'hA55A);
  endtask : t_result
  task automatic t_cont();
    int s0;
    i_serial_master_model.xfer({16'h048B, 16'h0}, 16, rx);
    check("mode", settings, 16'h048B);
    check("pullup on", pull, 1'b1);
    s0 = starts;
    done_pulse(16'h1234);
    check("restart", starts > s0, 1'b1);
  endtask : t_cont
  // Main sequence: reset for five cycles, then the scenarios
  initial begin
    srst      = 1'b1;
    conv_done = 1'b0;
    conv_data = 16'h0000;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    repeat (3) @(posedge mclk);
    check("reset", settings, 16'h058B);
    check("idle ready", rdy_n, 1'b1);
    check("idle oe", oe, 1'b0);
    t_refused();
    t_write();
    t_result();
    t_cont();
    conclude();
  end
  // Watchdog: about eighteen times the expected run
  initial begin
    #200000;
    num_errors++;
    conclude();
  end
endmodule : conv_settings_test
